// >>> dv/sncr_far_model.sv
`timescale 1ns/1ps
// high-side port and nonvolatile store: each start is answered by a done pulse some cycles later
module sncr_far_model #(
    parameter int WAKE_CYC = 7,
    parameter int NVM_CYC = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wake_start,
    input wire logic nvm_start,
    output logic wake_done,
    output logic nvm_done
);
    int wake_reg;
    int nvm_reg;
    // done is a one-cycle pulse, not a held level, so a busy flag that never clears shows up
    always_ff @(posedge clk) begin
        wake_done <= !rst && wake_reg == 1;
        nvm_done <= !rst && nvm_reg == 1;
        wake_reg <= rst ? 0 : (wake_start ? WAKE_CYC : (wake_reg > 0 ? wake_reg - 1 : 0));
        nvm_reg <= rst ? 0 : (nvm_start ? NVM_CYC : (nvm_reg > 0 ? nvm_reg - 1 : 0));
    end
endmodule

// >>> dv/stack_node_control_regs_tb.sv
`timescale 1ns/1ps
`include "sncr_defs.svh"
module stack_node_control_regs_tb;
    import sncr_pkg::*;
    typedef struct {sncr_byte_type cnt; sncr_mask_type en; sncr_count_type idle;} sncr_row_type;
    logic clk, rst, wr, rd, gchk, asel, frame, wdone, ndone, hit, rvalid, srp, shut, wstart, blk, nstart, nbusy, amode;
    sncr_byte_type addr, wdata, rdata, gid;
    sncr_count_type gpio, node, idle;
    sncr_key_type key_a, key_b;
    sncr_mask_type ov, uv, ovf, uvf, en;
    int mismatches = 0;
    int n_compared = 0;
    sncr_row_type rows[4] = '{'{8'h00, 16'h0000, 5'h01}, '{8'h01, 16'h0001, 5'h01},
        '{8'h08, 16'h00ff, 5'h08}, '{8'h10, 16'hffff, 5'h10}};

    sncr_control_regs dut (.CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .GROUP_CHECK(gchk), .GROUP_MATCH_VALUE_IN(gid),
        .GROUP_HIT(hit), .ADDR_SEL(asel), .GPIO_ADDR(gpio), .FRAME_RX(frame), .NODE_ID(node),
        .AUTO_ADDR_MODE(amode), .SOFT_RESET_PULSE(srp), .SHUTDOWN_REQ(shut), .WAKE_DONE(wdone),
        .WAKE_TONE_START(wstart), .UPSTREAM_BLOCK(blk), .UNLOCK_KEY_A(key_a), .UNLOCK_KEY_B(key_b),
        .NVM_DONE(ndone), .NVM_PROGRAM_START(nstart), .NVM_BUSY(nbusy), .OV_RAW(ov), .UV_RAW(uv),
        .OV_FAULT(ovf), .UV_FAULT(uvf), .CELL_ENABLE(en), .IDLE_CHANNEL(idle));
    sncr_far_model u_far (.clk(clk), .rst(rst), .wake_start(wstart), .nvm_start(nstart),
        .wake_done(wdone), .nvm_done(ndone));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // strobes are lowered at the next falling edge, so back-to-back calls never collide
    task automatic wr_reg(input sncr_byte_type a, input sncr_byte_type d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input sncr_byte_type a, input sncr_byte_type exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rvalid, 1'b1, "read valid");
        chk(rdata, exp, "read data");
    endtask

    // bounded wait for the wake and save sequences to finish
    task automatic wait_idle();
        int i;
        for (i = 0; i < 60 && (blk !== 1'b0 || nbusy !== 1'b0); i++) @(negedge clk);
        if (i == 60) begin
            mismatches++;
            $display("[FAIL] %0t wait limit reached", $time);
            end_sim();
        end
    endtask

    initial begin
        rst = 1'b1;
        {wr, rd, gchk, asel, frame} = '0;
        {addr, wdata, gid, gpio, key_a, key_b} = '0;
        ov = 16'hffff;
        uv = 16'h5555;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk(en, 16'hffff, "reset enable");
        chk(node, 5'h00, "reset node");
        rd_reg(8'h0b, 8'h00);
        rd_reg(8'h0c, 8'h00);
        rd_reg(8'h0d, 8'h10);
        rd_reg(8'h20, 8'h00);
        $display("reset test done");
        // cell count rows, never above 16 and reserved bits zero
        foreach (rows[i]) begin
            wr_reg(8'h0d, rows[i].cnt);
            @(negedge clk);
            chk(en, rows[i].en, "cell enable");
            chk(idle, rows[i].idle, "idle channel");
            @(negedge clk);
            chk(ovf, rows[i].en, "ov mask");
            chk(uvf, rows[i].en & 16'h5555, "uv mask");
            rd_reg(8'h0d, rows[i].cnt);
        end
        $display("cell count test done");
        wr_reg(8'h0b, 8'h05);
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            gid = (k == 0) ? 8'h05 : ((k == 1) ? 8'h15 : 8'h04);
            gchk = 1'b1;
            @(negedge clk);
            gchk = 1'b0;
            chk(hit, k == 0, "group hit");
        end
        $display("group test done");
        wr_reg(8'h0c, 8'h20);
        chk(wstart, 1'b1, "wake start");
        chk(blk, 1'b1, "upstream block");
        rd_reg(8'h0c, 8'h20);
        wait_idle();
        rd_reg(8'h0c, 8'h00);
        $display("wake test done");
        // link powerdown period is taken as three or more, so a plain save needs no counter hold
        key_b = `SNCR_KEY_B;
        wr_reg(8'h0c, 8'h10);
        chk(nbusy, 1'b0, "save refused");
        key_a = `SNCR_KEY_A;
        wr_reg(8'h0c, 8'h10);
        chk(nstart, 1'b1, "save start");
        rd_reg(8'h0c, 8'h10);
        wait_idle();
        rd_reg(8'h0c, 8'h00);
        $display("save test done");
        gpio = 5'h13;
        wr_reg(8'h0c, 8'h08);
        chk(node, 5'h13, "gpio address");
        rd_reg(8'h0c, 8'h00);
        wr_reg(8'h0a, 8'h07);
        chk(node, 5'h13, "node write ignored");
        asel = 1'b1;
        wr_reg(8'h0c, 8'h08);
        chk(amode, 1'b1, "auto mode");
        chk(node, 5'h13, "select keeps node");
        wr_reg(8'h0a, 8'h07);
        chk(node, 5'h07, "node write taken");
        @(negedge clk);
        frame = 1'b1;
        @(negedge clk);
        frame = 1'b0;
        chk(amode, 1'b0, "frame ends auto");
        $display("address test done");
        wr_reg(8'h0c, 8'h40);
        chk(shut, 1'b1, "shutdown");
        wr_reg(8'h0c, 8'h80);
        chk(srp, 1'b1, "reinit pulse");
        @(negedge clk);
        chk(shut, 1'b0, "reinit clears");
        chk(node, 5'h00, "reinit node");
        rd_reg(8'h0b, 8'h00);
        $display("shutdown and reinit test done");
        end_sim();
    end
endmodule

// >>> src/sncr_cell_if.sv
`timescale 1ns/1ps
// active cell count out to the channel map, masks back
interface sncr_cell_if;
    import sncr_pkg::*;
    sncr_count_type count;
    sncr_mask_type enable;
    sncr_count_type idle;
    modport map (input count, output enable, output idle);
    modport user (output count, input enable, input idle);
endinterface

// >>> src/sncr_cell_map.sv
`timescale 1ns/1ps
`include "sncr_defs.svh"
module sncr_cell_map #(
    parameter int N_CELLS = `SNCR_MAX_CELLS
) (
    sncr_cell_if.map cells
);
    import sncr_pkg::*;

    // ----------------------------------------------------------------
    // channel enable and idle channel
    // ----------------------------------------------------------------
    // channels drop from the top, so channel i is used when i < count;
    // reserved counts above the limit simply leave every channel on
    function automatic sncr_mask_type enable_of(input sncr_count_type cnt);
        sncr_mask_type m;
        m = '0;
        for (int i = 0; i < N_CELLS; i++) begin
            m[i] = (i < int'(cnt));
        end
        return m;
    endfunction

    // idle channel is numbered from one; a count of zero rests on the first input
    always_comb begin
        cells.enable = enable_of(cells.count);
        cells.idle = (cells.count == 5'h00) ? 5'h01 : cells.count;
    end
endmodule

// >>> src/sncr_control_regs.sv
`timescale 1ns/1ps
`include "sncr_defs.svh"
module sncr_control_regs (
    input wire logic CLK,
    input wire logic RESET,
    input wire sncr_pkg::sncr_byte_type REG_ADDR,
    input wire sncr_pkg::sncr_byte_type REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output sncr_pkg::sncr_byte_type REG_RDATA,
    output logic REG_RVALID,
    input wire logic GROUP_CHECK,
    input wire sncr_pkg::sncr_byte_type GROUP_MATCH_VALUE_IN,
    output logic GROUP_HIT,
    input wire logic ADDR_SEL,
    input wire sncr_pkg::sncr_count_type GPIO_ADDR,
    input wire logic FRAME_RX,
    output sncr_pkg::sncr_count_type NODE_ID,
    output logic AUTO_ADDR_MODE,
    output logic SOFT_RESET_PULSE,
    output logic SHUTDOWN_REQ,
    input wire logic WAKE_DONE,
    output logic WAKE_TONE_START,
    output logic UPSTREAM_BLOCK,
    input wire sncr_pkg::sncr_key_type UNLOCK_KEY_A,
    input wire sncr_pkg::sncr_key_type UNLOCK_KEY_B,
    input wire logic NVM_DONE,
    output logic NVM_PROGRAM_START,
    output logic NVM_BUSY,
    input wire sncr_pkg::sncr_mask_type OV_RAW,
    input wire sncr_pkg::sncr_mask_type UV_RAW,
    output sncr_pkg::sncr_mask_type OV_FAULT,
    output sncr_pkg::sncr_mask_type UV_FAULT,
    output sncr_pkg::sncr_mask_type CELL_ENABLE,
    output sncr_pkg::sncr_count_type IDLE_CHANNEL
);
    import sncr_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic rst_int;
    logic soft_reg, soft_next;
    logic [3:0] group_reg, group_next;
    sncr_count_type count_reg, count_next;
    sncr_count_type node_reg, node_next;
    logic auto_reg, auto_next;
    logic shut_reg, shut_next;
    logic wake_reg, wake_next;
    logic wake_start_reg, wake_start_next;
    logic hit_reg, hit_next;
    sncr_byte_type rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    sncr_mask_type ov_reg, ov_next, uv_reg, uv_next;
    sncr_mask_type en_reg, en_next;
    sncr_count_type idle_reg, idle_next;
    logic wr_ctrl, wr_group, wr_cells, wr_node;
    logic nvm_busy, nvm_start;
    logic gpio_load, auto_set;
    sncr_byte_type ctrl_view;

    // ----------------------------------------------------------------
    // register bus decode
    // ----------------------------------------------------------------
    function automatic logic wr_hit(input logic wr, input sncr_byte_type a, input sncr_byte_type off);
        return wr && (a == off);
    endfunction

    // soft reinit acts one cycle after its write, so the write itself completes cleanly
    assign rst_int = RESET || soft_reg;
    assign wr_ctrl = wr_hit(REG_WR, REG_ADDR, `SNCR_OFF_CTRL);
    assign wr_group = wr_hit(REG_WR, REG_ADDR, `SNCR_OFF_GROUP);
    assign wr_cells = wr_hit(REG_WR, REG_ADDR, `SNCR_OFF_CELLS);
    assign wr_node = wr_hit(REG_WR, REG_ADDR, `SNCR_OFF_NODE_ID);
    assign gpio_load = wr_ctrl && REG_WDATA[`SNCR_BIT_ADDR_ASSIGN] && !ADDR_SEL;
    assign auto_set = wr_ctrl && REG_WDATA[`SNCR_BIT_ADDR_ASSIGN] && ADDR_SEL;

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    sncr_cell_if cells();
    assign cells.count = count_reg;

    sncr_cell_map #(.N_CELLS(`SNCR_MAX_CELLS)) u_map (
        .cells(cells)
    );

    // host must keep the keys and link timeout set up before a save
    sncr_nvm_seq u_nvm (
        .clk(CLK),
        .rst(rst_int),
        .req(wr_ctrl && REG_WDATA[`SNCR_BIT_NVM_SAVE]),
        .key_a(UNLOCK_KEY_A),
        .key_b(UNLOCK_KEY_B),
        .done(NVM_DONE),
        .busy(nvm_busy),
        .start(nvm_start)
    );

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // reserved bits are not stored, so nonzero writes there have no effect
    always_comb begin
        group_next = group_reg;
        count_next = count_reg;
        node_next = node_reg;
        if (wr_group) begin
            group_next = REG_WDATA[3:0];
        end
        if (wr_cells) begin
            count_next = REG_WDATA[4:0];
        end
        // the select itself never touches the id; only explicit loads do
        if (gpio_load) begin
            node_next = GPIO_ADDR;
        end else if (wr_node && auto_reg) begin
            node_next = REG_WDATA[4:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (rst_int) begin
            group_reg <= `SNCR_RST_GROUP;
            count_reg <= `SNCR_RST_COUNT;
            node_reg <= `SNCR_RST_NODE;
        end else begin
            group_reg <= group_next;
            count_reg <= count_next;
            node_reg <= node_next;
        end
    end

    // ----------------------------------------------------------------
    // device control actions
    // ----------------------------------------------------------------
    // a new auto set beats a frame clear in the same cycle; a wake request while the block is up is dropped, even as WAKE_DONE clears it
    always_comb begin
        auto_next = auto_reg;
        if (auto_set) begin
            auto_next = 1'b1;
        end else if (FRAME_RX || gpio_load) begin
            auto_next = 1'b0;
        end
        shut_next = shut_reg || (wr_ctrl && REG_WDATA[`SNCR_BIT_SHUTDOWN]);
        wake_start_next = wr_ctrl && REG_WDATA[`SNCR_BIT_WAKE] && !wake_reg;
        wake_next = wake_reg;
        if (wake_start_next) begin
            wake_next = 1'b1;
        end else if (WAKE_DONE && !wake_start_reg) begin
            wake_next = 1'b0;
        end
    end

    // soft pulse is cleared by the hard reset only, it is what drives the soft one
    always_ff @(posedge CLK) begin
        if (RESET) begin
            soft_reg <= 1'b0;
        end else begin
            soft_reg <= soft_next;
        end
    end

    assign soft_next = wr_ctrl && REG_WDATA[`SNCR_BIT_SOFT_RESET] && !soft_reg;

    always_ff @(posedge CLK) begin
        if (rst_int) begin
            auto_reg <= 1'b0;
            shut_reg <= 1'b0;
            wake_reg <= 1'b0;
            wake_start_reg <= 1'b0;
        end else begin
            auto_reg <= auto_next;
            shut_reg <= shut_next;
            wake_reg <= wake_next;
            wake_start_reg <= wake_start_next;
        end
    end

    // ----------------------------------------------------------------
    // read path and group match
    // ----------------------------------------------------------------
    // assign bit shows only auto mode; in gpio mode it is a pure strobe
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[`SNCR_BIT_WAKE] = wake_reg;
        ctrl_view[`SNCR_BIT_NVM_SAVE] = nvm_busy;
        ctrl_view[`SNCR_BIT_ADDR_ASSIGN] = auto_reg;
        rvalid_next = REG_RD;
        rdata_next = `SNCR_UNMAPPED_DATA;
        if (REG_RD) begin
            unique case (REG_ADDR)
                `SNCR_OFF_NODE_ID: rdata_next = {3'h0, node_reg};
                `SNCR_OFF_GROUP: rdata_next = {4'h0, group_reg};
                `SNCR_OFF_CTRL: rdata_next = ctrl_view;
                `SNCR_OFF_CELLS: rdata_next = {3'h0, count_reg};
                default: rdata_next = `SNCR_UNMAPPED_DATA;
            endcase
        end
        hit_next = GROUP_CHECK && (GROUP_MATCH_VALUE_IN == {`SNCR_GROUP_HIGH, group_reg});
    end

    always_ff @(posedge CLK) begin
        if (rst_int) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            hit_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            hit_reg <= hit_next;
        end
    end

    // ----------------------------------------------------------------
    // channel masking
    // ----------------------------------------------------------------
    // faults are registered so a count change masks on the next edge, never glitching
    always_comb begin
        en_next = cells.enable;
        idle_next = cells.idle;
        ov_next = OV_RAW & cells.enable;
        uv_next = UV_RAW & cells.enable;
    end

    always_ff @(posedge CLK) begin
        if (rst_int) begin
            en_reg <= '0;
            idle_reg <= 5'h00;
            ov_reg <= '0;
            uv_reg <= '0;
        end else begin
            en_reg <= en_next;
            idle_reg <= idle_next;
            ov_reg <= ov_next;
            uv_reg <= uv_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign REG_RDATA = rdata_reg;
    assign REG_RVALID = rvalid_reg;
    assign GROUP_HIT = hit_reg;
    assign NODE_ID = node_reg;
    assign AUTO_ADDR_MODE = auto_reg;
    assign SOFT_RESET_PULSE = soft_reg;
    assign SHUTDOWN_REQ = shut_reg;
    assign WAKE_TONE_START = wake_start_reg;
    assign UPSTREAM_BLOCK = wake_reg;
    assign NVM_PROGRAM_START = nvm_start;
    assign NVM_BUSY = nvm_busy;
    assign OV_FAULT = ov_reg;
    assign UV_FAULT = uv_reg;
    assign CELL_ENABLE = en_reg;
    assign IDLE_CHANNEL = idle_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_group_high;
        @(posedge CLK) disable iff (rst_int)
        (GROUP_CHECK && GROUP_MATCH_VALUE_IN[7:4] != 4'h0) |=> !GROUP_HIT;
    endproperty
    a_group_high: assert property (p_group_high) else $error("group hit with high nibble set");

    property p_soft_reset;
        @(posedge CLK) disable iff (RESET)
        (wr_ctrl && REG_WDATA[7] && !soft_reg) |=> SOFT_RESET_PULSE ##1 (!SOFT_RESET_PULSE && !SHUTDOWN_REQ
            && NODE_ID == 5'h00 && !UPSTREAM_BLOCK);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reinit did not reset state");

    property p_ctrl_bit7;
        @(posedge CLK) disable iff (RESET)
        REG_RVALID |-> !(REG_RDATA[7] && $past(REG_ADDR) == `SNCR_OFF_CTRL);
    endproperty
    a_ctrl_bit7: assert property (p_ctrl_bit7) else $error("reinit bit read as one");

    property p_shutdown;
        @(posedge CLK) disable iff (rst_int)
        (wr_ctrl && REG_WDATA[6]) |=> SHUTDOWN_REQ [*2];
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown request not held");

    property p_wake_start;
        @(posedge CLK) disable iff (rst_int)
        (wr_ctrl && REG_WDATA[5] && !UPSTREAM_BLOCK) |=> (WAKE_TONE_START && UPSTREAM_BLOCK) ##1 !WAKE_TONE_START;
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("wake tone not started");

    property p_wake_hold;
        @(posedge CLK) disable iff (rst_int)
        (UPSTREAM_BLOCK && !WAKE_DONE && !SOFT_RESET_PULSE) |=> UPSTREAM_BLOCK;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("upstream unblocked before tone done");

    property p_wake_done;
        @(posedge CLK) disable iff (rst_int)
        (UPSTREAM_BLOCK && WAKE_DONE && !WAKE_TONE_START && !(wr_ctrl && REG_WDATA[5])) |=> !UPSTREAM_BLOCK;
    endproperty
    a_wake_done: assert property (p_wake_done) else $error("wake bit stuck after tone done");

    property p_gpio_addr;
        @(posedge CLK) disable iff (rst_int)
        gpio_load |=> (NODE_ID == $past(GPIO_ADDR) && !AUTO_ADDR_MODE);
    endproperty
    a_gpio_addr: assert property (p_gpio_addr) else $error("gpio address not loaded");

    property p_auto_frame;
        @(posedge CLK) disable iff (rst_int)
        (AUTO_ADDR_MODE && FRAME_RX && !auto_set) |=> !AUTO_ADDR_MODE;
    endproperty
    a_auto_frame: assert property (p_auto_frame) else $error("auto mode survived a frame");

    property p_node_locked;
        @(posedge CLK) disable iff (rst_int)
        (!AUTO_ADDR_MODE && !gpio_load && !SOFT_RESET_PULSE) |=> $stable(NODE_ID);
    endproperty
    a_node_locked: assert property (p_node_locked) else $error("node id changed while locked");

    property p_sel_keeps_id;
        @(posedge CLK) disable iff (rst_int)
        ($changed(ADDR_SEL) && !REG_WR) |=> $stable(NODE_ID);
    endproperty
    a_sel_keeps_id: assert property (p_sel_keeps_id) else $error("select change moved node id");

    property p_enable_count;
        @(posedge CLK) disable iff (rst_int)
        (wr_cells && REG_WDATA[4:0] <= 5'h10) ##1 !wr_cells |=> ($countones(CELL_ENABLE) == int'(count_reg));
    endproperty
    a_enable_count: assert property (p_enable_count) else $error("enabled channels differ from count");

    property p_idle;
        @(posedge CLK) disable iff (rst_int) (!SOFT_RESET_PULSE && !wr_cells && $stable(count_reg))
        |=> (IDLE_CHANNEL == ((count_reg == 5'h00) ? 5'h01 : count_reg));
    endproperty
    a_idle: assert property (p_idle) else $error("idle channel wrong");

    property p_fault_mask;
        @(posedge CLK) disable iff (rst_int)
        ((OV_FAULT | UV_FAULT) & ~CELL_ENABLE) == 16'h0000;
    endproperty
    a_fault_mask: assert property (p_fault_mask) else $error("fault on unused channel");
endmodule

// >>> src/sncr_defs.svh
`ifndef SNCR_DEFS_SVH
`define SNCR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SNCR_OFF_NODE_ID 8'h0a
`define SNCR_OFF_GROUP 8'h0b
`define SNCR_OFF_CTRL 8'h0c
`define SNCR_OFF_CELLS 8'h0d

// ----------------------------------------------------------------
// device control bit positions
// ----------------------------------------------------------------
`define SNCR_BIT_SOFT_RESET 7
`define SNCR_BIT_SHUTDOWN 6
`define SNCR_BIT_WAKE 5
`define SNCR_BIT_NVM_SAVE 4
`define SNCR_BIT_ADDR_ASSIGN 3

// ----------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------
`define SNCR_GROUP_W 4
`define SNCR_NODE_W 5
`define SNCR_COUNT_W 5
`define SNCR_MAX_CELLS 16
`define SNCR_GROUP_HIGH 4'h0
`define SNCR_RST_GROUP 4'h0
`define SNCR_RST_NODE 5'h00
`define SNCR_RST_COUNT 5'h10
`define SNCR_UNMAPPED_DATA 8'h00

// ----------------------------------------------------------------
// nonvolatile save unlock keys
// ----------------------------------------------------------------
`define SNCR_KEY_A 32'h8c2db194
`define SNCR_KEY_B 32'ha375e60f

`endif

// >>> src/sncr_nvm_seq.sv
`timescale 1ns/1ps
`include "sncr_defs.svh"
module sncr_nvm_seq (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire sncr_pkg::sncr_key_type key_a,
    input wire sncr_pkg::sncr_key_type key_b,
    input wire logic done,
    output logic busy,
    output logic start
);
    import sncr_pkg::*;

    sncr_nvm_state_type state_reg, state_next;
    logic start_reg, start_next;
    logic unlocked;

    // ----------------------------------------------------------------
    // save sequencer
    // ----------------------------------------------------------------
    assign unlocked = (key_a == `SNCR_KEY_A) && (key_b == `SNCR_KEY_B);

    // a request while burning is dropped: restarting mid-cycle could corrupt the array
    always_comb begin
        state_next = state_reg;
        start_next = 1'b0;
        unique case (state_reg)
            SNCR_NVM_IDLE: begin
                if (req && unlocked) begin
                    state_next = SNCR_NVM_BURN;
                    start_next = 1'b1;
                end
            end
            SNCR_NVM_BURN: begin
                if (done && !start_reg) begin
                    state_next = SNCR_NVM_IDLE;
                end
            end
            default: begin
                state_next = SNCR_NVM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= SNCR_NVM_IDLE;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_reg <= start_next;
        end
    end

    assign busy = (state_reg == SNCR_NVM_BURN);
    assign start = start_reg;

    property p_nvm_locked;
        @(posedge clk) disable iff (rst)
        (req && !unlocked) |=> !start;
    endproperty
    a_nvm_locked: assert property (p_nvm_locked) else $error("save started with wrong keys");

    property p_nvm_busy;
        @(posedge clk) disable iff (rst)
        (start || (busy && !done)) |-> busy ##1 busy;
    endproperty
    a_nvm_busy: assert property (p_nvm_busy) else $error("save bit not busy during burn");
endmodule

// >>> src/sncr_pkg.sv
package sncr_pkg;
    // ----------------------------------------------------------------
    // shared types
    // ----------------------------------------------------------------
    typedef logic [4:0] sncr_count_type;
    typedef logic [15:0] sncr_mask_type;
    typedef logic [7:0] sncr_byte_type;
    typedef logic [31:0] sncr_key_type;
    typedef enum logic [1:0] {
        SNCR_NVM_IDLE = 2'b01,
        SNCR_NVM_BURN = 2'b10
    } sncr_nvm_state_type;
endpackage
